// *** hdl/sclk_source_select.sv ***
// sample clock source selection, status report and pitch control top
//
// Operation
// - synthesizer offset adjusts in 1 Hz steps within plus or minus five percent.
// - preset video pull-up and pull-down offsets of 0.1 and 4 percent.
// - coarse command moves offset by 50 Hz up or down.
// - offset applies only in master mode, only to this unit.
// - offset unavailable when host link uses either serial bus mode.
// - automatic mode follows a valid input instead of internal oscillator.
// - failed reference in automatic mode reverts to internal clock as master when no other input is valid.
// - preferred input used while valid, else other inputs scanned in turn.
// - no valid input means effective mode becomes master.
// - each input reports no lock, lock, or sync.
// - fixed internal mode ignores valid inputs and stays on oscillator.
// - while slaved, host requests for a rate other than the external rate are refused; external rate kept.
// - detected rate differing from host rate raises mismatch flag.
// - playback accepted only for supported rate and resolution pairs.
// - synthesizer offers 44.1 kHz and 48 kHz base rates.
// - source and mode selection frozen while streaming.
module sclk_source_select
	import sclk_pkg::*;
(
	input  wire logic                     CORE_CLK,
	input  wire logic                     RST_N,
	input  wire logic                     CFG_MODE,
	input  wire sclk_src_t                CFG_PREF_SRC,
	input  wire logic                     CFG_BASE_48K,
	input  wire logic [1:0]               HOST_LINK_MODE,
	input  wire logic                     STREAMING,
	input  wire logic                     RATE_REQ,
	input  wire logic [RATE_W-1:0]        RATE_REQ_VALUE,
	input  wire logic                     PITCH_CMD_VALID,
	input  wire sclk_cmd_t                PITCH_CMD,
	input  wire logic [2:0]               IN_LOCK,
	input  wire logic [2:0]               IN_SYNC,
	input  wire logic [RATE_W-1:0]        IN_RATE_WORD,
	input  wire logic [RATE_W-1:0]        IN_RATE_MADI,
	input  wire logic [RATE_W-1:0]        IN_RATE_AES,
	input  wire logic [RATE_W-1:0]        PLAY_RATE,
	input  wire logic [5:0]               PLAY_BITS,
	output sclk_src_t                     CUR_SRC,
	output logic                          IS_MASTER,
	output sclk_sync_t                    STATE_WORD,
	output sclk_sync_t                    STATE_MADI,
	output sclk_sync_t                    STATE_AES,
	output logic [RATE_W-1:0]             HOST_RATE,
	output logic                          RATE_REQ_REFUSED,
	output logic [RATE_W-1:0]             SYNTH_RATE,
	output logic signed [OFS_W-1:0]       PITCH_OFFSET,
	output logic                          PITCH_AVAIL,
	output logic                          RATE_MISMATCH,
	output logic                          PLAY_FORMAT_OK
);

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	// lock and sync come from recovery circuits on other clocks
	logic [2:0] lock_s1, lock_s2, sync_s1, sync_s2;

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			lock_s1 <= '0;
			lock_s2 <= '0;
			sync_s1 <= '0;
			sync_s2 <= '0;
		end else begin
			lock_s1 <= IN_LOCK;
			lock_s2 <= lock_s1;
			sync_s1 <= IN_SYNC;
			sync_s2 <= sync_s1;
		end
	end

	// ------------------------------------------------------------
	// configuration latch
	// ------------------------------------------------------------
	logic      mode, next_mode;
	sclk_src_t pref, next_pref;
	logic      base48, next_base48;

	// selection frozen while streaming to avoid clock glitches mid-take
	always_comb begin
		next_mode   = mode;
		next_pref   = pref;
		next_base48 = base48;
		if (!STREAMING) begin
			next_mode   = CFG_MODE;
			next_pref   = CFG_PREF_SRC;
			next_base48 = CFG_BASE_48K;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			mode   <= MODE_AUTO;
			pref   <= SRC_INT;
			base48 <= 1'b1;
		end else begin
			mode   <= next_mode;
			pref   <= next_pref;
			base48 <= next_base48;
		end
	end

	// ------------------------------------------------------------
	// source selection
	// ------------------------------------------------------------
	// input index 0 word, 1 madi, 2 aes
	function automatic logic src_valid(input sclk_src_t s, input logic [2:0] lk);
		case (s)
			SRC_WORD: return lk[0];
			SRC_MADI: return lk[1];
			SRC_AES:  return lk[2];
			default:  return 1'b0;
		endcase
	endfunction

	sclk_src_t cur, next_cur;
	sclk_src_t cand;

	// scan order starts after the preferred input and wraps
	always_comb begin
		next_cur = SRC_INT;
		cand     = SRC_INT;
		if (mode == MODE_FIXED) begin
			next_cur = SRC_INT;
		end else if (src_valid(pref, lock_s2)) begin
			next_cur = pref;
		end else begin
			for (int i = 3; i >= 1; i--) begin
				cand = sclk_src_t'(2'((int'(pref) + i - 1) % 3 + 1));
				if (src_valid(cand, lock_s2))
					next_cur = cand;
			end
			// falls through to internal when nothing locks
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			cur <= SRC_INT;
		else
			cur <= next_cur;
	end

	// ------------------------------------------------------------
	// rate handling
	// ------------------------------------------------------------
	logic [RATE_W-1:0] host_rate, next_host_rate;
	logic              refused, next_refused;
	logic [RATE_W-1:0] ext_rate;
	logic [RATE_W-1:0] base_rate;
	logic              pitch_en;
	logic signed [OFS_W-1:0] offset;

	always_comb begin
		case (cur)
			SRC_WORD: ext_rate = IN_RATE_WORD;
			SRC_MADI: ext_rate = IN_RATE_MADI;
			SRC_AES:  ext_rate = IN_RATE_AES;
			default:  ext_rate = '0;
		endcase
		base_rate = base48 ? RATE_48K : RATE_44K1;
		pitch_en  = (cur == SRC_INT) && (HOST_LINK_MODE == HOST_SLOT);
	end

	// slaved: external rate wins, requests for any other rate are refused
	always_comb begin
		next_host_rate = host_rate;
		next_refused   = 1'b0;
		if (RATE_REQ) begin
			if (cur != SRC_INT && RATE_REQ_VALUE != ext_rate)
				next_refused = 1'b1;
			else
				next_host_rate = RATE_REQ_VALUE;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			host_rate <= RATE_48K;
			refused   <= 1'b0;
		end else begin
			host_rate <= next_host_rate;
			refused   <= next_refused;
		end
	end

	sclk_pitch u_pitch (
		.clk       (CORE_CLK),
		.rst_n     (RST_N),
		.enable    (pitch_en),
		.cmd_valid (PITCH_CMD_VALID),
		.cmd       (PITCH_CMD),
		.base_rate (base_rate),
		.offset    (offset)
	);

	sclk_rate_chk u_chk (
		.clk            (CORE_CLK),
		.rst_n          (RST_N),
		.detected_rate  (ext_rate),
		.detected_valid (cur != SRC_INT),
		.host_rate      (host_rate),
		.play_rate      (PLAY_RATE),
		.play_bits      (PLAY_BITS),
		.mismatch       (RATE_MISMATCH),
		.format_ok      (PLAY_FORMAT_OK)
	);

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	function automatic sclk_sync_t sstate(input logic lk, input logic sy);
		return !lk ? ST_NOLOCK : (sy ? ST_SYNC : ST_LOCK);
	endfunction

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			CUR_SRC          <= SRC_INT;
			IS_MASTER        <= 1'b1;
			STATE_WORD       <= ST_NOLOCK;
			STATE_MADI       <= ST_NOLOCK;
			STATE_AES        <= ST_NOLOCK;
			SYNTH_RATE       <= RATE_48K;
			PITCH_OFFSET     <= '0;
			PITCH_AVAIL      <= 1'b0;
			HOST_RATE        <= RATE_48K;
			RATE_REQ_REFUSED <= 1'b0;
		end else begin
			CUR_SRC          <= cur;
			IS_MASTER        <= (cur == SRC_INT);
			STATE_WORD       <= sstate(lock_s2[0], sync_s2[0]);
			STATE_MADI       <= sstate(lock_s2[1], sync_s2[1]);
			STATE_AES        <= sstate(lock_s2[2], sync_s2[2]);
			// offset only shapes the synth while this unit is master
			SYNTH_RATE       <= pitch_en ? RATE_W'($signed({1'b0, base_rate}) + offset)
				: base_rate;
			PITCH_OFFSET     <= offset;
			PITCH_AVAIL      <= pitch_en;
			HOST_RATE        <= host_rate;
			RATE_REQ_REFUSED <= refused;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_fixed;
		@(posedge CORE_CLK) disable iff (!RST_N)
		mode == MODE_FIXED |=> cur == SRC_INT;
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed mode left internal");

	property p_none;
		@(posedge CORE_CLK) disable iff (!RST_N)
		lock_s2 == 3'h0 |=> ##1 IS_MASTER && CUR_SRC == SRC_INT;
	endproperty
	a_none: assert property (p_none) else $error("no input but not master");

	property p_pref;
		@(posedge CORE_CLK) disable iff (!RST_N)
		mode == MODE_AUTO && pref != SRC_INT && src_valid(pref, lock_s2) |=> cur == pref;
	endproperty
	a_pref: assert property (p_pref) else $error("valid preferred input not used");

	property p_freeze;
		@(posedge CORE_CLK) disable iff (!RST_N)
		STREAMING |=> $stable(mode) && $stable(pref);
	endproperty
	a_freeze: assert property (p_freeze) else $error("selection changed while streaming");

	property p_refuse;
		@(posedge CORE_CLK) disable iff (!RST_N)
		RATE_REQ && cur != SRC_INT && RATE_REQ_VALUE != ext_rate
			|=> refused && $stable(host_rate);
	endproperty
	a_refuse: assert property (p_refuse) else $error("slave accepted rate");

	property p_serial;
		@(posedge CORE_CLK) disable iff (!RST_N)
		HOST_LINK_MODE != HOST_SLOT |=> $stable(offset) && !PITCH_AVAIL;
	endproperty
	a_serial: assert property (p_serial) else $error("pitch on serial link");

endmodule

// *** pkg/sclk_pkg.sv ***
// shared constants and types for the sample clock source select block
package sclk_pkg;

	// ------------------------------------------------------------
	// clock sources and modes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {SRC_INT, SRC_WORD, SRC_MADI, SRC_AES} sclk_src_t;
	typedef enum logic [1:0] {ST_NOLOCK, ST_LOCK, ST_SYNC} sclk_sync_t;
	// clock mode: automatic source following or fixed internal
	localparam logic MODE_AUTO  = 1'b0;
	localparam logic MODE_FIXED = 1'b1;
	// host connection modes; only the card slot allows pitch
	localparam logic [1:0] HOST_SLOT = 2'h0;

	// ------------------------------------------------------------
	// rates and pitch
	// ------------------------------------------------------------
	localparam int RATE_W = 18;
	localparam logic [RATE_W-1:0] RATE_44K1 = 18'h0ac44; // 44100 Hz
	localparam logic [RATE_W-1:0] RATE_48K  = 18'h0bb80; // 48000 Hz
	localparam int OFS_W = 14;
	localparam logic signed [OFS_W-1:0] FINE_STEP   = 14'sh0001; // 1 Hz
	localparam logic signed [OFS_W-1:0] COARSE_STEP = 14'sh0032; // 50 Hz
	localparam int SPAN_PCT  = 5;
	localparam int PULL_LO_PERMIL = 1;  // 0.1 %
	localparam int PULL_HI_PERMIL = 40; // 4 %
	// pitch commands
	typedef enum logic [3:0] {
		CMD_NONE, CMD_FINE_UP, CMD_FINE_DN, CMD_COARSE_UP, CMD_COARSE_DN,
		CMD_RESET, CMD_PU_LO, CMD_PD_LO, CMD_PU_HI, CMD_PD_HI
	} sclk_cmd_t;

	// supported playback resolutions
	localparam logic [5:0] BITS_16 = 6'h10;
	localparam logic [5:0] BITS_24 = 6'h18;
	localparam logic [5:0] BITS_32 = 6'h20;

endpackage

// *** hdl/sclk_pitch.sv ***
// synthesizer rate offset (pitch) accumulator
module sclk_pitch
	import sclk_pkg::*;
(
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     enable,
	input  wire logic                     cmd_valid,
	input  wire sclk_cmd_t                cmd,
	input  wire logic [RATE_W-1:0]        base_rate,
	output logic signed [OFS_W-1:0]       offset
);

	logic signed [OFS_W-1:0] next_offset;
	logic signed [OFS_W-1:0] limit;
	logic signed [OFS_W:0]   sum;

	// percent or per-mille of base rate as an offset
	function automatic logic signed [OFS_W-1:0] frac(input logic [RATE_W-1:0] r,
			input int num, input int den);
		logic [31:0] p;
		p = (32'(r) * 32'(num)) / 32'(den);
		return $signed(p[OFS_W-1:0]);
	endfunction

	// ------------------------------------------------------------
	// next offset
	// ------------------------------------------------------------
	// steps saturate at the span so a held key cannot wrap around
	always_comb begin
		limit       = frac(base_rate, SPAN_PCT, 100);
		sum         = '0;
		next_offset = offset;
		if (enable && cmd_valid) begin
			case (cmd)
				CMD_FINE_UP:   sum = (OFS_W+1)'(offset) + (OFS_W+1)'(FINE_STEP);
				CMD_FINE_DN:   sum = (OFS_W+1)'(offset) - (OFS_W+1)'(FINE_STEP);
				CMD_COARSE_UP: sum = (OFS_W+1)'(offset) + (OFS_W+1)'(COARSE_STEP);
				CMD_COARSE_DN: sum = (OFS_W+1)'(offset) - (OFS_W+1)'(COARSE_STEP);
				CMD_PU_LO:     sum = (OFS_W+1)'(frac(base_rate, PULL_LO_PERMIL, 1000));
				CMD_PD_LO:     sum = -(OFS_W+1)'(frac(base_rate, PULL_LO_PERMIL, 1000));
				CMD_PU_HI:     sum = (OFS_W+1)'(frac(base_rate, PULL_HI_PERMIL, 1000));
				CMD_PD_HI:     sum = -(OFS_W+1)'(frac(base_rate, PULL_HI_PERMIL, 1000));
				default:       sum = '0;
			endcase
			if (cmd == CMD_NONE)
				next_offset = offset;
			else if (sum > (OFS_W+1)'(limit))
				next_offset = limit;
			else if (sum < -(OFS_W+1)'(limit))
				next_offset = -limit;
			else
				next_offset = sum[OFS_W-1:0]; // reset command lands here with zero
		end
	end

	// offset register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			offset <= '0;
		else
			offset <= next_offset;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_span;
		@(posedge clk) disable iff (!rst_n)
		(offset <= frac(base_rate, SPAN_PCT, 100)) && (offset >= -frac(base_rate, SPAN_PCT, 100));
	endproperty
	a_span: assert property (p_span) else $error("pitch offset outside span");

	property p_coarse;
		@(posedge clk) disable iff (!rst_n)
		enable && cmd_valid && cmd == CMD_COARSE_UP && offset == 14'sh0000
			|=> offset == COARSE_STEP;
	endproperty
	a_coarse: assert property (p_coarse) else $error("coarse step not 50");

	property p_fine;
		@(posedge clk) disable iff (!rst_n)
		enable && cmd_valid && cmd == CMD_FINE_DN && offset == 14'sh0000
			|=> offset == -FINE_STEP;
	endproperty
	a_fine: assert property (p_fine) else $error("fine step not 1");

endmodule

// *** hdl/sclk_rate_chk.sv ***
// playback format acceptance and rate mismatch detection
module sclk_rate_chk
	import sclk_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic [RATE_W-1:0]   detected_rate,
	input  wire logic                detected_valid,
	input  wire logic [RATE_W-1:0]   host_rate,
	input  wire logic [RATE_W-1:0]   play_rate,
	input  wire logic [5:0]          play_bits,
	output logic                     mismatch,
	output logic                     format_ok
);

	logic next_mismatch;
	logic next_format_ok;

	// accepted rates: 32k, and the 44.1k/48k families up to quad speed
	function automatic logic rate_ok(input logic [RATE_W-1:0] r);
		return r == 18'h07d00 || r == RATE_44K1 || r == RATE_48K ||
			r == 18'h15888 || r == 18'h17700 || r == 18'h2b110 || r == 18'h2ee00;
	endfunction

	// ------------------------------------------------------------
	// decisions
	// ------------------------------------------------------------
	always_comb begin
		next_mismatch  = detected_valid && (detected_rate != host_rate);
		next_format_ok = rate_ok(play_rate) &&
			(play_bits == BITS_16 || play_bits == BITS_24 || play_bits == BITS_32);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mismatch  <= 1'b0;
			format_ok <= 1'b0;
		end else begin
			mismatch  <= next_mismatch;
			format_ok <= next_format_ok;
		end
	end

	property p_mis;
		@(posedge clk) disable iff (!rst_n)
		detected_valid && detected_rate != host_rate |=> mismatch;
	endproperty
	a_mis: assert property (p_mis) else $error("mismatch not flagged");

	property p_fmt;
		@(posedge clk) disable iff (!rst_n)
		play_bits == 6'h08 |=> !format_ok;
	endproperty
	a_fmt: assert property (p_fmt) else $error("8 bit accepted");

endmodule

// *** tb/sclk_src_model.sv ***
// model of the external sources feeding reference clocks
module sclk_src_model
	import sclk_pkg::*;
(
	input  wire logic              clk,
	input  wire logic [2:0]        lock,
	input  wire logic [2:0]        sync,
	input  wire logic [RATE_W-1:0] rate_w,
	input  wire logic [RATE_W-1:0] rate_m,
	input  wire logic [RATE_W-1:0] rate_a,
	output logic [2:0]             in_lock,
	output logic [2:0]             in_sync,
	output logic [RATE_W-1:0]      in_rate_w,
	output logic [RATE_W-1:0]      in_rate_m,
	output logic [RATE_W-1:0]      in_rate_a
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// line levels
	// ----------------------------------------
	// a dead input shows a churning rate, every bit flipping each cycle
	initial begin
		in_lock = 3'h0;
		in_sync = 3'h0;
		in_rate_w = '0;
		in_rate_m = '0;
		in_rate_a = '0;
	end
	always @(posedge clk) begin
		in_lock <= lock;
		in_sync <= sync & lock; // sync only with a lock
		in_rate_w <= lock[0] ? rate_w : ~in_rate_w;
		in_rate_m <= lock[1] ? rate_m : ~in_rate_m;
		in_rate_a <= lock[2] ? rate_a : ~in_rate_a;
	end
endmodule

// *** tb/tb_sclk_source_select.sv ***
// self-checking bench of the sample clock source select block
module tb_sclk_source_select;
	timeunit 1ns;
	timeprecision 1ps;
	import sclk_pkg::*;
	logic CORE_CLK, RST_N, CFG_MODE, CFG_BASE_48K, STREAMING, RATE_REQ, PITCH_CMD_VALID;
	sclk_src_t CFG_PREF_SRC, CUR_SRC;
	sclk_cmd_t PITCH_CMD;
	sclk_sync_t STATE_WORD, STATE_MADI, STATE_AES;
	logic [1:0] HOST_LINK_MODE;
	logic [2:0] IN_LOCK, IN_SYNC, lock, sync;
	logic [RATE_W-1:0] RATE_REQ_VALUE, IN_RATE_WORD, IN_RATE_MADI, IN_RATE_AES, PLAY_RATE;
	logic [RATE_W-1:0] HOST_RATE, SYNTH_RATE, rate_w, rate_m, rate_a;
	logic [5:0] PLAY_BITS;
	logic IS_MASTER, RATE_REQ_REFUSED, PITCH_AVAIL, RATE_MISMATCH, PLAY_FORMAT_OK;
	logic signed [OFS_W-1:0] PITCH_OFFSET;
	int failures, n_checks;
	logic [31:0] seed;
	// ----------------------------------------
	// clock, partner, design
	// ----------------------------------------
	initial begin
		CORE_CLK = 1'b0;
		forever #2.5 CORE_CLK = ~CORE_CLK;
	end
	sclk_src_model sclk_src_model_i (.clk(CORE_CLK), .lock(lock), .sync(sync),
		.rate_w(rate_w), .rate_m(rate_m), .rate_a(rate_a), .in_lock(IN_LOCK),
		.in_sync(IN_SYNC), .in_rate_w(IN_RATE_WORD), .in_rate_m(IN_RATE_MADI),
		.in_rate_a(IN_RATE_AES));
	sclk_source_select sclk_source_select_i (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
		.CFG_MODE(CFG_MODE), .CFG_PREF_SRC(CFG_PREF_SRC), .CFG_BASE_48K(CFG_BASE_48K),
		.HOST_LINK_MODE(HOST_LINK_MODE), .STREAMING(STREAMING), .RATE_REQ(RATE_REQ),
		.RATE_REQ_VALUE(RATE_REQ_VALUE), .PITCH_CMD_VALID(PITCH_CMD_VALID),
		.PITCH_CMD(PITCH_CMD), .IN_LOCK(IN_LOCK), .IN_SYNC(IN_SYNC),
		.IN_RATE_WORD(IN_RATE_WORD), .IN_RATE_MADI(IN_RATE_MADI), .IN_RATE_AES(IN_RATE_AES),
		.PLAY_RATE(PLAY_RATE), .PLAY_BITS(PLAY_BITS), .CUR_SRC(CUR_SRC), .IS_MASTER(IS_MASTER),
		.STATE_WORD(STATE_WORD), .STATE_MADI(STATE_MADI), .STATE_AES(STATE_AES),
		.HOST_RATE(HOST_RATE), .RATE_REQ_REFUSED(RATE_REQ_REFUSED), .SYNTH_RATE(SYNTH_RATE),
		.PITCH_OFFSET(PITCH_OFFSET), .PITCH_AVAIL(PITCH_AVAIL),
		.RATE_MISMATCH(RATE_MISMATCH), .PLAY_FORMAT_OK(PLAY_FORMAT_OK));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic fmt_ok(input logic [RATE_W-1:0] r, input logic [5:0] b);
		logic rate_good;
		rate_good = r inside {18'h07d00, 18'h0ac44, 18'h0bb80, 18'h15888, 18'h17700,
			18'h2b110, 18'h2ee00};
		return rate_good && (b inside {BITS_16, BITS_24, BITS_32});
	endfunction
	task automatic bad(input string m);
		failures++;
		$display("BAD t=%0t %s", $time, m);
	endtask
	task automatic chk_b(input logic g, input logic e, input string m);
		n_checks++;
		if (g !== e) bad(m);
	endtask
	task automatic chk_v(input logic [RATE_W-1:0] g, input logic [RATE_W-1:0] e, input string m);
		n_checks++;
		if (g !== e) bad(m);
	endtask
	task automatic chk_src(input sclk_src_t g, input sclk_src_t e, input string m);
		n_checks++;
		if (g !== e) bad(m);
	endtask
	task automatic chk_st(input sclk_sync_t g, input sclk_sync_t e, input string m);
		n_checks++;
		if (g !== e) bad(m);
	endtask
	task automatic chk_o(input logic signed [OFS_W-1:0] g, input int e, input string m);
		n_checks++;
		if (g !== OFS_W'(e)) bad(m);
	endtask
	task automatic settle();
		repeat (6) @(negedge CORE_CLK);
	endtask
	// back to back pitch pulses, one per cycle
	task automatic pitch(input sclk_cmd_t c, input int n);
		repeat (n) begin
			PITCH_CMD_VALID = 1'b1;
			PITCH_CMD = c;
			@(negedge CORE_CLK);
		end
		PITCH_CMD_VALID = 1'b0;
		settle();
	endtask
	// answer stands one cycle, one edge after the taking edge
	task automatic rate_req(input logic [RATE_W-1:0] v, input logic refused);
		RATE_REQ = 1'b1;
		RATE_REQ_VALUE = v;
		@(negedge CORE_CLK);
		RATE_REQ = 1'b0;
		@(negedge CORE_CLK);
		chk_b(RATE_REQ_REFUSED, refused, "refusal pulse");
		settle();
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		sclk_cmd_t pre[4];
		int pre_ofs[4];
		sclk_sync_t st[3];
		logic [RATE_W-1:0] r;
		logic [5:0] b;
		pre = '{CMD_PU_LO, CMD_PD_LO, CMD_PU_HI, CMD_PD_HI};
		pre_ofs = '{48, -48, 1920, -1920}; // permil of 48000, floored
		failures = 0;
		n_checks = 0;
		seed = 32'h0000c665;
		// reset held, automatic mode, 48k base, every request idle
		{RST_N, CFG_MODE, CFG_BASE_48K, STREAMING, RATE_REQ, PITCH_CMD_VALID} = 6'h08;
		CFG_PREF_SRC = SRC_INT;
		PITCH_CMD = CMD_NONE;
		HOST_LINK_MODE = HOST_SLOT;
		{lock, sync} = 6'h00;
		{rate_w, rate_m, rate_a} = {RATE_48K, RATE_48K, RATE_48K};
		{RATE_REQ_VALUE, PLAY_RATE, PLAY_BITS} = {RATE_48K, RATE_48K, BITS_24};
		repeat (3) @(negedge CORE_CLK);
		chk_src(CUR_SRC, SRC_INT, "reset source");
		chk_v(HOST_RATE, RATE_48K, "reset host rate");
		RST_N = 1'b1;
		settle();
		chk_b(IS_MASTER, 1'b1, "master without inputs");
		chk_b(PITCH_AVAIL, 1'b1, "pitch available");
		// pitch steps and saturation at 48k
		pitch(CMD_FINE_UP, 3);
		pitch(CMD_FINE_DN, 1);
		chk_o(PITCH_OFFSET, 2, "fine steps");
		pitch(CMD_COARSE_UP, 2);
		pitch(CMD_COARSE_DN, 1);
		chk_o(PITCH_OFFSET, 52, "coarse steps");
		chk_v(SYNTH_RATE, RATE_48K + 18'd52, "synth offset");
		pitch(CMD_COARSE_UP, 60);
		pitch(CMD_FINE_UP, 1);
		chk_o(PITCH_OFFSET, 2400, "upper limit");
		pitch(CMD_COARSE_DN, 120);
		chk_o(PITCH_OFFSET, -2400, "lower limit");
		pitch(CMD_RESET, 1);
		chk_o(PITCH_OFFSET, 0, "reset command");
		// single steps from zero
		pitch(CMD_COARSE_UP, 1);
		chk_o(PITCH_OFFSET, 50, "single coarse step");
		pitch(CMD_RESET, 1);
		pitch(CMD_FINE_DN, 1);
		chk_o(PITCH_OFFSET, -1, "single fine step");
		foreach (pre[i]) begin
			pitch(pre[i], 1);
			chk_o(PITCH_OFFSET, pre_ofs[i], "video preset");
		end
		pitch(CMD_RESET, 1);
		// serial bus links lock pitch out
		for (int m = 1; m < 3; m++) begin
			HOST_LINK_MODE = 2'(m);
			pitch(CMD_FINE_UP, 2);
			chk_b(PITCH_AVAIL, 1'b0, "pitch on serial link");
			chk_o(PITCH_OFFSET, 0, "ignored on serial link");
		end
		HOST_LINK_MODE = HOST_SLOT;
		CFG_BASE_48K = 1'b0;
		settle();
		chk_v(SYNTH_RATE, RATE_44K1, "base 44.1k");
		CFG_BASE_48K = 1'b1;
		// per input status
		for (int i = 0; i < 3; i++) begin
			lock = 3'h1 << i;
			sync = 3'h0;
			settle();
			st = '{STATE_WORD, STATE_MADI, STATE_AES};
			chk_st(st[i], ST_LOCK, "lock state");
			sync = lock;
			settle();
			st = '{STATE_WORD, STATE_MADI, STATE_AES};
			chk_st(st[i], ST_SYNC, "sync state");
		end
		// preferred word, then fallback through the scan
		rate_req(RATE_48K, 1'b0);
		CFG_PREF_SRC = SRC_WORD;
		lock = 3'h1;
		settle();
		chk_src(CUR_SRC, SRC_WORD, "follow word");
		chk_b(IS_MASTER, 1'b0, "slaved");
		pitch(CMD_FINE_UP, 1);
		chk_o(PITCH_OFFSET, 0, "pitch while slaved");
		rate_req(RATE_44K1, 1'b1);
		chk_v(HOST_RATE, RATE_48K, "rate kept");
		rate_req(RATE_48K, 1'b0);
		rate_m = 18'h07d00;
		lock = 3'h2;
		settle();
		chk_src(CUR_SRC, SRC_MADI, "scan to madi");
		chk_b(RATE_MISMATCH, 1'b1, "32k against 48k");
		lock = 3'h0;
		settle();
		chk_src(CUR_SRC, SRC_INT, "fall back");
		chk_b(IS_MASTER, 1'b1, "master again");
		chk_b(RATE_MISMATCH, 1'b0, "no mismatch as master");
		rate_req(RATE_44K1, 1'b0);
		chk_v(HOST_RATE, RATE_44K1, "rate accepted");
		rate_req(RATE_48K, 1'b0);
		// cyclic scan from aes, then frozen while streaming
		CFG_PREF_SRC = SRC_AES;
		lock = 3'h1;
		settle();
		chk_src(CUR_SRC, SRC_WORD, "aes wraps to word");
		STREAMING = 1'b1;
		CFG_PREF_SRC = SRC_MADI;
		lock = 3'h3;
		settle();
		chk_src(CUR_SRC, SRC_WORD, "frozen selection");
		STREAMING = 1'b0;
		settle();
		chk_src(CUR_SRC, SRC_MADI, "selection released");
		CFG_MODE = MODE_FIXED;
		settle();
		chk_src(CUR_SRC, SRC_INT, "fixed internal");
		chk_b(IS_MASTER, 1'b1, "fixed master");
		// random formats, legal ones mixed in
		repeat (40) begin
			seed = xs(seed);
			r = seed[3] ? RATE_W'(seed[31:14]) : (seed[4] ? 18'h17700 : 18'h2b110);
			b = seed[5] ? seed[11:6] : BITS_16;
			PLAY_RATE = r;
			PLAY_BITS = b;
			repeat (3) @(negedge CORE_CLK);
			chk_b(PLAY_FORMAT_OK, fmt_ok(r, b), "format check");
		end
		PLAY_RATE = 18'h055f0;
		PLAY_BITS = 6'h08;
		repeat (3) @(negedge CORE_CLK);
		chk_b(PLAY_FORMAT_OK, 1'b0, "22k 8 bit");
		summarize();
	end
	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	initial begin
		#200us;
		failures++;
		summarize();
	end
endmodule
